// *** common/rhi_pkg.sv ***
// constants and types for the receiver host interface block
package rhi_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  // power toggle pulse detection
  localparam int unsigned TOGGLE_MIN_US  = 100;
  localparam int unsigned TOGGLE_CYC     = (TOGGLE_MIN_US * 20) ;
  // manual reset minimum width
  localparam int unsigned MRST_MIN_NS    = 1000;
  localparam int unsigned MRST_CYC       = (MRST_MIN_NS * 20 + 999) / 1000;
  // second mark timing
  localparam int unsigned SECOND_MS      = 1000;
  localparam int unsigned MARK_HIGH_MS   = 200;
  localparam int unsigned UTC_DELAY_MS   = 300;
  localparam int unsigned SECOND_CYC     = SECOND_MS * (CLK_HZ / 1000);
  localparam int unsigned MARK_HIGH_CYC  = MARK_HIGH_MS * (CLK_HZ / 1000);
  localparam int unsigned UTC_DELAY_CYC  = UTC_DELAY_MS * (CLK_HZ / 1000);
  // async serial port
  localparam int unsigned BAUD_DEFAULT   = 4800;
  localparam int unsigned TX_STOP_BITS   = 2;
  localparam logic [3:0]  RATE_SEL_RST   = 4'h0;
  localparam logic [1:0]  PROTO_RST      = 2'h0; // text sentence protocol
  // spi slave
  localparam int unsigned FIFO_DEPTH     = 1024;
  localparam int unsigned FIFO_AW        = 10;
  localparam logic [7:0]  IDLE0_RST      = 8'hA7;
  localparam logic [7:0]  IDLE1_RST      = 8'hB4;
  localparam int unsigned SCK_MAX_KHZ    = 6800;

  typedef enum logic [1:0] {
    RHI_HIBERNATE, RHI_FULL, RHI_CYCLING, RHI_PERIODIC
  } rhi_pwr_t;
  typedef enum logic [1:0] {
    RHI_TX_IDLE, RHI_TX_START, RHI_TX_DATA, RHI_TX_STOP
  } rhi_tx_t;
  typedef enum logic [1:0] {
    RHI_RX_IDLE, RHI_RX_START, RHI_RX_DATA, RHI_RX_STOP
  } rhi_rx_t;
endpackage

// *** core/rhi_core.sv ***
// receiver host interface: power toggle, second mark, async and spi ports
// Overview of operation
// - pulse in hibernate or fixed-rate cycling mode moves to full power
// - pulse in periodic wake mode starts exactly one wake cycle
// - pulse in full power begins orderly shutdown
// - toggle seen after rising edge and high level for minimum time
// - detector re-arms only after input stays low minimum time
// - manual reset active low, minimum width, clears clock and config
// - power indicator low in low-power states, high at full power
// - second mark: 200 ms high pulse once per second
// - utc message queued 300 ms after each second mark
// - port type chosen by fixed strap, not at run time
// - transmitter sends start, eight data, two stop bits
// - receiver takes start, eight data, one or more stop bits
// - flow control: host permission input, device ready output
// - after reset async port uses text protocol at 4800 bps
// - rates 4.8 to 921.6 kbps selectable, protocol changeable
// - spi slave: mosi, miso, select and clock on the shared pads
// - separate independent 1024-byte transmit and receive fifos
// - programmable two-byte idle pattern per path, default A7 B4
// - tx fifo disables when empty, idle pattern sent until re-enabled
// - rx counts idle repeats, stops writing fifo until pattern broken
// - fifo fill-level interrupts, sync error flag, software port reset
// - spi works up to 6.8 MHz serial clock
// - spi mode 1: clock idles low, sample falling, change rising
// - one byte shifted back for every byte shifted in
`timescale 1ns/10ps
module rhi_core (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        link_clock,      // spi sck, second domain
  input  wire logic        manual_reset_in_n,
  input  wire logic        power_toggle_in,
  input  wire logic        mode_periodic,   // low-power target is periodic
  input  wire logic        mode_cycling,    // low-power target is cycling
  input  wire logic        wake_cycle_done,
  input  wire logic        shutdown_done,
  output logic             power_state_out,
  output logic             second_mark_out,
  output logic             utc_msg_queue,
  input  wire logic        strap_spi,
  input  wire logic [3:0]  rate_sel,
  input  wire logic        rate_load,
  input  wire logic [1:0]  proto_sel,
  output logic [1:0]       proto_out,
  input  wire logic        serial_in_pad,
  output logic             serial_out_pad,
  output logic             serial_out_oe_n,
  input  wire logic        send_permission_in, // also spi clock pad
  input  wire logic        slave_select_pad,   // ready pad, spi select
  output logic             ready_to_send_out,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        rx_pop,
  input  wire logic        tx_fifo_enable,
  output logic             tx_fifo_enabled,
  input  wire logic [15:0] tx_idle_pat,
  input  wire logic [15:0] rx_idle_pat,
  input  wire logic [7:0]  rx_idle_limit,
  input  wire logic [10:0] tx_level_th,
  input  wire logic [10:0] rx_level_th,
  output logic             tx_level_irq,
  output logic             rx_level_irq,
  output logic             sync_err,
  input  wire logic        spi_port_reset,
  output logic [10:0]      tx_count,
  output logic [10:0]      rx_count,
  output logic             tx_full,
  output logic             rx_full,
  output logic             tx_empty,
  output logic             rx_empty
);
  // manual reset synchroniser and width filter
  logic [1:0] mr_s_r;
  logic [4:0] mr_cnt_r;
  logic       soft_rst_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mr_s_r <= 2'h3; mr_cnt_r <= 5'h00; soft_rst_r <= 1'b0;
    end else if (clk_en) begin
      mr_s_r <= {mr_s_r[0], manual_reset_in_n};
      if (mr_s_r[1]) mr_cnt_r <= 5'h00;
      else if (mr_cnt_r != 5'(rhi_pkg::MRST_CYC)) mr_cnt_r <= mr_cnt_r + 5'h01;
      soft_rst_r <= (mr_cnt_r == 5'(rhi_pkg::MRST_CYC));
    end
  end
  wire rst_act = soft_rst_r;

  // power toggle synchroniser and pulse detector
  logic [2:0]  tg_s_r;
  logic [11:0] tg_cnt_r;
  logic        tg_armed_r, tg_hi_seen_r;
  wire         tg_lvl = tg_s_r[1];
  wire         tg_rise = tg_s_r[1] & ~tg_s_r[2];
  wire         tg_full = (tg_cnt_r == 12'(rhi_pkg::TOGGLE_CYC));
  wire         tg_pulse = tg_lvl & tg_hi_seen_r & tg_armed_r & tg_full;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tg_s_r <= 3'h0; tg_cnt_r <= 12'h000;
      tg_armed_r <= 1'b0; tg_hi_seen_r <= 1'b0;
    end else if (clk_en) begin
      tg_s_r <= {tg_s_r[1:0], power_toggle_in};
      if (tg_rise || (tg_lvl != tg_s_r[2])) tg_cnt_r <= 12'h000;
      else if (!tg_full) tg_cnt_r <= tg_cnt_r + 12'h001;
      if (tg_rise) tg_hi_seen_r <= 1'b1;
      else if (!tg_lvl) tg_hi_seen_r <= 1'b0;
      if (tg_pulse) tg_armed_r <= 1'b0;
      else if (!tg_lvl && tg_full) tg_armed_r <= 1'b1;
    end
  end

  // power state machine
  rhi_pkg::rhi_pwr_t pwr_r, pwr_nxt;
  logic              shut_r;
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      rhi_pkg::RHI_HIBERNATE, rhi_pkg::RHI_CYCLING:
        if (tg_pulse) pwr_nxt = rhi_pkg::RHI_FULL;
      rhi_pkg::RHI_PERIODIC:
        if (tg_pulse) pwr_nxt = rhi_pkg::RHI_FULL;
      rhi_pkg::RHI_FULL: begin
        if (shut_r && shutdown_done) begin
          if (mode_cycling) pwr_nxt = rhi_pkg::RHI_CYCLING;
          else if (mode_periodic) pwr_nxt = rhi_pkg::RHI_PERIODIC;
          else pwr_nxt = rhi_pkg::RHI_HIBERNATE;
        end
      end
      default: pwr_nxt = rhi_pkg::RHI_HIBERNATE;
    endcase
  end
  logic wake_one_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwr_r <= rhi_pkg::RHI_HIBERNATE; shut_r <= 1'b0; wake_one_r <= 1'b0;
      power_state_out <= 1'b0;
    end else if (clk_en) begin
      if (rst_act) begin
        pwr_r <= rhi_pkg::RHI_HIBERNATE; shut_r <= 1'b0; wake_one_r <= 1'b0;
      end else begin
        pwr_r <= pwr_nxt;
        // a single periodic wake ends by itself, no shutdown pulse needed
        if (pwr_r == rhi_pkg::RHI_PERIODIC && tg_pulse)
          wake_one_r <= 1'b1;
        if (pwr_r == rhi_pkg::RHI_FULL && tg_pulse)
          shut_r <= 1'b1;
        else if (wake_one_r && wake_cycle_done) shut_r <= 1'b1;
        if (pwr_nxt != rhi_pkg::RHI_FULL) begin
          shut_r <= 1'b0; wake_one_r <= 1'b0;
        end
      end
      // low as soon as a manual reset acts, not one cycle later
      power_state_out <= !rst_act &&
        (pwr_nxt == rhi_pkg::RHI_FULL);
    end
  end

  // second mark and utc queue timing
  logic [24:0] sec_cnt_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_cnt_r <= 25'h0; second_mark_out <= 1'b0; utc_msg_queue <= 1'b0;
    end else if (clk_en) begin
      if (rst_act || sec_cnt_r == 25'(rhi_pkg::SECOND_CYC - 1))
        sec_cnt_r <= 25'h0;
      else sec_cnt_r <= sec_cnt_r + 25'h1;
      second_mark_out <= !rst_act &&
        (sec_cnt_r < 25'(rhi_pkg::MARK_HIGH_CYC));
      utc_msg_queue <= (sec_cnt_r == 25'(rhi_pkg::UTC_DELAY_CYC));
    end
  end

  // strap latched once after reset release
  logic strap_done_r, spi_mode_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_done_r <= 1'b0; spi_mode_r <= 1'b0;
    end else if (clk_en && !strap_done_r) begin
      strap_done_r <= 1'b1; spi_mode_r <= strap_spi;
    end
  end

  // baud divisor table, clock cycles per bit
  logic [3:0] rate_r;
  logic [1:0] proto_r;
  logic [12:0] div_w;
  assign div_w = (rate_r == 4'h1) ? 13'd2083 : (rate_r == 4'h2) ? 13'd1042 :
                 (rate_r == 4'h3) ? 13'd521  : (rate_r == 4'h4) ? 13'd347  :
                 (rate_r == 4'h5) ? 13'd174  : (rate_r == 4'h6) ? 13'd87   :
                 (rate_r == 4'h7) ? 13'd43   : (rate_r == 4'h8) ? 13'd22   :
                 13'd4167;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rate_r <= rhi_pkg::RATE_SEL_RST; proto_r <= rhi_pkg::PROTO_RST;
      proto_out <= rhi_pkg::PROTO_RST;
    end else if (clk_en) begin
      if (rst_act) begin
        rate_r <= rhi_pkg::RATE_SEL_RST; proto_r <= rhi_pkg::PROTO_RST;
      end else if (rate_load) begin
        rate_r <= rate_sel; proto_r <= proto_sel;
      end
      proto_out <= proto_r;
    end
  end

  // async pad synchronisers (rx data and send permission)
  logic [1:0] rxp_s_r, cts_s_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin rxp_s_r <= 2'h3; cts_s_r <= 2'h0; end
    else if (clk_en) begin
      rxp_s_r <= {rxp_s_r[0], serial_in_pad};
      cts_s_r <= {cts_s_r[0], send_permission_in};
    end
  end

  // async transmitter: 1 start, 8 data, 2 stop
  rhi_pkg::rhi_tx_t ut_st_r;
  logic [12:0] ut_div_r;
  logic [3:0]  ut_bit_r;
  logic [7:0]  ut_sh_r;
  logic        ut_line_r;
  wire ut_tick = (ut_div_r == 13'h0);
  wire ut_take = !spi_mode_r && ut_st_r == rhi_pkg::RHI_TX_IDLE &&
                 tx_valid && cts_s_r[1];
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ut_st_r <= rhi_pkg::RHI_TX_IDLE; ut_div_r <= 13'h0; ut_bit_r <= 4'h0;
      ut_sh_r <= 8'h00; ut_line_r <= 1'b1;
    end else if (clk_en) begin
      ut_div_r <= ut_tick ? div_w - 13'h1 : ut_div_r - 13'h1;
      case (ut_st_r)
        rhi_pkg::RHI_TX_IDLE: if (ut_take) begin
          ut_sh_r <= tx_data; ut_st_r <= rhi_pkg::RHI_TX_START;
          ut_div_r <= div_w - 13'h1; ut_line_r <= 1'b0;
        end
        rhi_pkg::RHI_TX_START: if (ut_tick) begin
          ut_line_r <= ut_sh_r[0]; ut_bit_r <= 4'h0;
          ut_st_r <= rhi_pkg::RHI_TX_DATA;
        end
        rhi_pkg::RHI_TX_DATA: if (ut_tick) begin
          if (ut_bit_r == 4'h7) begin
            ut_line_r <= 1'b1; ut_bit_r <= 4'h0;
            ut_st_r <= rhi_pkg::RHI_TX_STOP;
          end else begin
            ut_sh_r <= {1'b0, ut_sh_r[7:1]};
            ut_line_r <= ut_sh_r[1]; ut_bit_r <= ut_bit_r + 4'h1;
          end
        end
        default: if (ut_tick) begin
          if (ut_bit_r == 4'(rhi_pkg::TX_STOP_BITS - 1))
            ut_st_r <= rhi_pkg::RHI_TX_IDLE;
          else ut_bit_r <= ut_bit_r + 4'h1;
        end
      endcase
    end
  end

  // async receiver: accepts one or more stop bits
  rhi_pkg::rhi_rx_t ur_st_r;
  logic [12:0] ur_div_r;
  logic [3:0]  ur_bit_r;
  logic [7:0]  ur_sh_r;
  logic        ur_done_r;
  wire ur_in = rxp_s_r[1];
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ur_st_r <= rhi_pkg::RHI_RX_IDLE; ur_div_r <= 13'h0; ur_bit_r <= 4'h0;
      ur_sh_r <= 8'h00; ur_done_r <= 1'b0;
    end else if (clk_en) begin
      ur_done_r <= 1'b0;
      if (ur_div_r != 13'h0) ur_div_r <= ur_div_r - 13'h1;
      case (ur_st_r)
        rhi_pkg::RHI_RX_IDLE: if (!spi_mode_r && !ur_in) begin
          ur_div_r <= {1'b0, div_w[12:1]}; ur_st_r <= rhi_pkg::RHI_RX_START;
        end
        rhi_pkg::RHI_RX_START: if (ur_div_r == 13'h0) begin
          ur_div_r <= div_w - 13'h1; ur_bit_r <= 4'h0;
          ur_st_r <= ur_in ? rhi_pkg::RHI_RX_IDLE : rhi_pkg::RHI_RX_DATA;
        end
        rhi_pkg::RHI_RX_DATA: if (ur_div_r == 13'h0) begin
          ur_sh_r <= {ur_in, ur_sh_r[7:1]}; ur_div_r <= div_w - 13'h1;
          if (ur_bit_r == 4'h7) ur_st_r <= rhi_pkg::RHI_RX_STOP;
          else ur_bit_r <= ur_bit_r + 4'h1;
        end
        default: if (ur_div_r == 13'h0) begin
          ur_done_r <= ur_in;
          ur_st_r <= rhi_pkg::RHI_RX_IDLE;
        end
      endcase
    end
  end

  // spi link domain: mode 1, sample falling, shift rising
  // select pad is active low; the sck pad is the link clock
  // miso is re-timed on clock, so sck must stay at or below 6.8 MHz
  logic [2:0] lk_bit_r;
  logic [7:0] lk_in_r, lk_out_r, lk_byte_r;
  logic       lk_tog_r, lk_req_tog_r;
  logic [7:0] lk_load_r;            // next tx byte, held stable by core
  always_ff @(negedge link_clock or negedge nrst) begin
    if (!nrst) begin
      lk_bit_r <= 3'h0; lk_in_r <= 8'h00; lk_byte_r <= 8'h00;
      lk_tog_r <= 1'b0;
    end else if (slave_select_pad) lk_bit_r <= 3'h0;
    else begin
      lk_in_r <= {lk_in_r[6:0], serial_in_pad};
      lk_bit_r <= lk_bit_r + 3'h1;
      if (lk_bit_r == 3'h7) begin
        lk_byte_r <= {lk_in_r[6:0], serial_in_pad};
        lk_tog_r <= ~lk_tog_r;                         // byte event
      end
    end
  end
  always_ff @(posedge link_clock or negedge nrst) begin
    if (!nrst) begin lk_out_r <= 8'h00; lk_req_tog_r <= 1'b0; end
    else if (!slave_select_pad) begin
      if (lk_bit_r == 3'h0) begin
        lk_out_r <= lk_load_r;
        lk_req_tog_r <= ~lk_req_tog_r;
      end else lk_out_r <= {lk_out_r[6:0], 1'b0};
    end
  end
  wire spi_miso = (lk_bit_r == 3'h0) ? lk_load_r[7] : lk_out_r[7];

  // core side: toggle crossings of link events
  logic [2:0] by_s_r, rq_s_r;
  logic [1:0] cs_s_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin by_s_r <= 3'h0; rq_s_r <= 3'h0; cs_s_r <= 2'h3; end
    else if (clk_en) begin
      by_s_r <= {by_s_r[1:0], lk_tog_r};
      rq_s_r <= {rq_s_r[1:0], lk_req_tog_r};
      cs_s_r <= {cs_s_r[0], slave_select_pad};
    end
  end
  wire spi_byte = spi_mode_r && (by_s_r[2] != by_s_r[1]);
  wire spi_load = spi_mode_r && (rq_s_r[2] != rq_s_r[1]);

  // fifos, 1024 bytes each, independent
  logic [7:0]  tx_mem [0:rhi_pkg::FIFO_DEPTH-1];
  logic [7:0]  rx_mem [0:rhi_pkg::FIFO_DEPTH-1];
  logic [10:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic        tx_en_r, idle_ph_r, rx_ph_r, rx_gate_r;
  logic [7:0]  idle_cnt_r;
  wire [10:0] tx_cnt_w = tx_wp_r - tx_rp_r;
  wire [10:0] rx_cnt_w = rx_wp_r - rx_rp_r;
  wire tx_full_w = (tx_cnt_w == 11'(rhi_pkg::FIFO_DEPTH));
  wire rx_full_w = (rx_cnt_w == 11'(rhi_pkg::FIFO_DEPTH));
  wire tx_push = tx_valid && tx_ready;
  wire tx_pop_u = ut_take;
  wire tx_pop_s = spi_load && tx_en_r && tx_cnt_w != 11'h0;
  wire tx_pop = tx_pop_u | tx_pop_s;
  wire [7:0] tx_head = tx_mem[tx_rp_r[9:0]];
  wire [7:0] rx_idle_b = rx_ph_r ? rx_idle_pat[7:0] : rx_idle_pat[15:8];
  wire rx_is_idle = (lk_byte_r == rx_idle_b);
  wire rx_src = spi_mode_r ? spi_byte : ur_done_r;
  wire [7:0] rx_byte = spi_mode_r ? lk_byte_r : ur_sh_r;
  wire rx_push = rx_src && !rx_full_w &&
                 !(spi_mode_r && rx_gate_r && rx_is_idle);
  wire rx_pop_ok = rx_pop && rx_cnt_w != 11'h0;
  wire port_rst = rst_act || spi_port_reset;
  always_ff @(posedge clock) begin
    if (clk_en && tx_push) tx_mem[tx_wp_r[9:0]] <= tx_data;
    if (clk_en && rx_push) rx_mem[rx_wp_r[9:0]] <= rx_byte;
  end

  // fifo pointers, idle handling, flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_wp_r <= 11'h0; tx_rp_r <= 11'h0; rx_wp_r <= 11'h0; rx_rp_r <= 11'h0;
      tx_en_r <= 1'b0; idle_ph_r <= 1'b1; rx_ph_r <= 1'b0; // first byte preset
      rx_gate_r <= 1'b0; idle_cnt_r <= 8'h00; lk_load_r <= rhi_pkg::IDLE0_RST;
      sync_err <= 1'b0;
    end else if (clk_en) begin
      if (port_rst) begin
        tx_wp_r <= 11'h0; tx_rp_r <= 11'h0; rx_wp_r <= 11'h0; rx_rp_r <= 11'h0;
        tx_en_r <= 1'b0; idle_ph_r <= 1'b1; rx_ph_r <= 1'b0;
        rx_gate_r <= 1'b0; idle_cnt_r <= 8'h00; sync_err <= 1'b0;
      end else begin
        if (tx_push) tx_wp_r <= tx_wp_r + 11'h1;
        if (tx_pop) tx_rp_r <= tx_rp_r + 11'h1;
        if (rx_push) rx_wp_r <= rx_wp_r + 11'h1;
        if (rx_pop_ok) rx_rp_r <= rx_rp_r + 11'h1;
        if (tx_en_r && tx_cnt_w == 11'h0) tx_en_r <= 1'b0;
        else if (tx_fifo_enable) tx_en_r <= 1'b1;
        // next byte for the link: data when enabled, else idle
        if (spi_load) begin
          if (tx_pop_s) lk_load_r <= tx_head;
          else begin
            lk_load_r <= idle_ph_r ? tx_idle_pat[15:8] : tx_idle_pat[7:0];
            idle_ph_r <= ~idle_ph_r;
          end
        end
        if (spi_byte) begin
          if (rx_is_idle) begin
            rx_ph_r <= ~rx_ph_r;
            if (rx_ph_r && idle_cnt_r != rx_idle_limit)
              idle_cnt_r <= idle_cnt_r + 8'h01;
            if (rx_ph_r && idle_cnt_r + 8'h01 >= rx_idle_limit)
              rx_gate_r <= 1'b1;
          end else begin
            rx_ph_r <= 1'b0; idle_cnt_r <= 8'h00; rx_gate_r <= 1'b0;
          end
        end
        // select released mid-byte, or overflow, is a sync error
        if ((cs_s_r[1] && lk_bit_r != 3'h0) || (spi_byte && rx_full_w))
          sync_err <= 1'b1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial_out_pad <= 1'b1; serial_out_oe_n <= 1'b0;
      ready_to_send_out <= 1'b0; tx_ready <= 1'b0;
      rx_data <= 8'h00; rx_valid <= 1'b0; tx_fifo_enabled <= 1'b0;
      tx_level_irq <= 1'b0; rx_level_irq <= 1'b0;
      tx_count <= 11'h0; rx_count <= 11'h0; tx_full <= 1'b0; rx_full <= 1'b0;
      tx_empty <= 1'b1; rx_empty <= 1'b1;
    end else if (clk_en) begin
      serial_out_pad <= spi_mode_r ? spi_miso : ut_line_r;
      serial_out_oe_n <= spi_mode_r && cs_s_r[1];
      ready_to_send_out <= !spi_mode_r && tx_cnt_w != 11'h0;
      tx_ready <= !tx_full_w && !(tx_push && tx_cnt_w == 11'h3FF);
      rx_data <= rx_mem[rx_rp_r[9:0]];
      rx_valid <= rx_cnt_w != 11'h0;
      tx_fifo_enabled <= tx_en_r;
      tx_level_irq <= tx_cnt_w <= tx_level_th;
      rx_level_irq <= rx_cnt_w >= rx_level_th && rx_cnt_w != 11'h0;
      tx_count <= tx_cnt_w; rx_count <= rx_cnt_w;
      tx_full <= tx_full_w; rx_full <= rx_full_w;
      tx_empty <= tx_cnt_w == 11'h0; rx_empty <= rx_cnt_w == 11'h0;
    end
  end
endmodule // rhi_core

// *** verification/rhi_host_model.sv ***
// spi master model standing at the host side of the data port
`timescale 1ns/10ps
module rhi_host_model (
  output logic     sck,
  output logic     cs_n,
  output logic     mosi,
  input wire logic miso
);
  // clock idles low and stands still outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one whole byte, msb first; hp is half period, 80 ns or slower
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      input int hp);
    cs_n = 1'b0;
    #(2 * hp);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b1;
      mosi = d[i]; // change on rising edge
      #hp;
      sck = 1'b0;
      q[i] = miso; // sample on falling edge
      #hp;
    end
    cs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale value
    #(4 * hp);
  endtask
endmodule // rhi_host_model

// *** verification/rhi_core_properties.sv ***
// port assertions for the receiver host interface core
`timescale 1ns/10ps
module rhi_core_props (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        power_toggle_in,
  input wire logic        manual_reset_in_n,
  input wire logic        mode_periodic,
  input wire logic        strap_spi,
  input wire logic        slave_select_pad,
  input wire logic        spi_port_reset,
  input wire logic        power_state_out,
  input wire logic        second_mark_out,
  input wire logic        utc_msg_queue,
  input wire logic        serial_out_oe_n,
  input wire logic        tx_empty,
  input wire logic        tx_full,
  input wire logic        rx_empty,
  input wire logic [10:0] tx_count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [10:0] hi_r;
  logic        long_r;
  logic [4:0]  lo_r;
  // counts toggle high time and manual reset low time
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hi_r <= 11'h000;
      long_r <= 1'b0;
      lo_r <= 5'h00;
    end else begin
      hi_r <= power_toggle_in ? hi_r + {10'h000, hi_r != 11'h7FF} : 11'h000;
      long_r <= !power_state_out && (long_r || hi_r >= 11'h7C6);
      lo_r <= manual_reset_in_n ? 5'h00 : lo_r + {4'h0, lo_r != 5'h1F};
    end
  end
  property p_wake; $rose(power_state_out) && !mode_periodic |-> long_r;
  endproperty
  a_wake: assert property (p_wake) else $error("wake too early");
  property p_mrst; lo_r == 5'h18 |-> !power_state_out && tx_empty; endproperty
  a_mrst: assert property (p_mrst) else $error("no reset");
  property p_mark; $rose(second_mark_out) |=> second_mark_out [*8];
  endproperty
  a_mark: assert property (p_mark) else $error("mark short");
  property p_utc; $rose(utc_msg_queue) |=> !utc_msg_queue ##1 !utc_msg_queue;
  endproperty
  a_utc: assert property (p_utc) else $error("utc pulse");
  property p_sel; strap_spi && slave_select_pad [*6] |-> serial_out_oe_n;
  endproperty
  a_sel: assert property (p_sel) else $error("miso driven");
  property p_full; tx_full |-> tx_count == 11'h400; endproperty
  a_full: assert property (p_full) else $error("full count");
  property p_prst; spi_port_reset |-> ##[1:4] tx_empty && rx_empty;
  endproperty
  a_prst: assert property (p_prst) else $error("port reset");
  property p_excl; tx_empty |-> !tx_full; endproperty
  a_excl: assert property (p_excl) else $error("full and empty");
  c_on: cover property ($rose(power_state_out));
  c_off: cover property ($fell(power_state_out));
  c_rx: cover property ($fell(rx_empty));
endmodule // rhi_core_props
bind rhi_core rhi_core_props i_props (.clock(clock), .nrst(nrst),
  .power_toggle_in(power_toggle_in), .manual_reset_in_n(manual_reset_in_n),
  .mode_periodic(mode_periodic), .strap_spi(strap_spi),
  .slave_select_pad(slave_select_pad), .spi_port_reset(spi_port_reset),
  .power_state_out(power_state_out), .second_mark_out(second_mark_out),
  .utc_msg_queue(utc_msg_queue), .serial_out_oe_n(serial_out_oe_n),
  .tx_empty(tx_empty), .tx_full(tx_full), .rx_empty(rx_empty),
  .tx_count(tx_count));

// *** verification/rhi_core_tb.sv ***
// self-checking bench for the receiver host interface core
`timescale 1ns/10ps
module rhi_core_tb;
  logic clock, nrst, clk_en, mrst_n, tog, m_per, m_cyc, wk_done, sd_done;
  logic strap_spi, rate_load, tx_valid, rx_pop, tx_en, prst, sck, cs_n;
  logic mosi, miso, oe_n, pwr, mark, utc, rts, tx_rdy, rx_valid, tx_on;
  logic tx_irq, rx_irq, sync_err, tx_full, rx_full, tx_empty, rx_empty;
  logic [1:0]  proto_sel, proto_out;
  logic [3:0]  rate_sel;
  logic [7:0]  tx_data, rx_data, got;
  logic [10:0] tx_th, rx_th, tx_count, rx_count;
  int          err_total, checks_done;
  rhi_host_model i_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  rhi_core i_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en),
    .link_clock(sck), .manual_reset_in_n(mrst_n), .power_toggle_in(tog),
    .mode_periodic(m_per), .mode_cycling(m_cyc), .wake_cycle_done(wk_done),
    .shutdown_done(sd_done), .power_state_out(pwr), .second_mark_out(mark),
    .utc_msg_queue(utc), .strap_spi(strap_spi), .rate_sel(rate_sel),
    .rate_load(rate_load), .proto_sel(proto_sel), .proto_out(proto_out),
    .serial_in_pad(mosi), .serial_out_pad(miso), .serial_out_oe_n(oe_n),
    .send_permission_in(sck), .slave_select_pad(cs_n),
    .ready_to_send_out(rts), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_rdy), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_pop(rx_pop), .tx_fifo_enable(tx_en), .tx_fifo_enabled(tx_on),
    .tx_idle_pat(16'hB4A7), .rx_idle_pat(16'hA7B4), .rx_idle_limit(8'h02),
    .tx_level_th(tx_th), .rx_level_th(rx_th), .tx_level_irq(tx_irq),
    .rx_level_irq(rx_irq), .sync_err(sync_err), .spi_port_reset(prst),
    .tx_count(tx_count), .rx_count(rx_count), .tx_full(tx_full),
    .rx_full(rx_full), .tx_empty(tx_empty), .rx_empty(rx_empty));
  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task pulse_tog(input int hi, input int lo);
    tog <= 1'b1;
    cyc(hi);
    tog <= 1'b0;
    cyc(lo);
  endtask
  // short pulse, short re-arm, wake and orderly shutdown
  task t_toggle;
    pulse_tog(1000, 2100);
    chk(pwr, 0);
    pulse_tog(2100, 500);
    chk(pwr, 1);
    pulse_tog(2100, 2100);
    chk(pwr, 1);
    pulse_tog(2100, 0);
    sd_done <= 1'b1;
    cyc(4);
    sd_done <= 1'b0;
    cyc(2100);
    chk(pwr, 0);
  endtask
  // protocol change, then short and long manual reset
  task t_mrst;
    proto_sel <= 2'h1;
    rate_sel <= 4'h8;
    rate_load <= 1'b1;
    cyc(1);
    rate_load <= 1'b0;
    pulse_tog(2100, 2100);
    chk(proto_out, 1);
    mrst_n <= 1'b0;
    cyc(10);
    mrst_n <= 1'b1;
    cyc(5);
    chk(pwr, 1);
    mrst_n <= 1'b0;
    cyc(30);
    mrst_n <= 1'b1;
    cyc(5);
    chk({pwr, proto_out}, 0);
  endtask
  // idle answers, data both ways, idle suppression, port reset
  task t_spi;
    i_host.xfer(8'h3C, got, 80);
    chk(got, 8'hA7);
    i_host.xfer(8'h5A, got, 80);
    chk(got, 8'hB4);
    cyc(20);
    chk({rx_count, rx_data, rx_irq}, {11'd2, 8'h3C, 1'b1});
    rx_pop <= 1'b1;
    cyc(1);
    rx_pop <= 1'b0;
    cyc(4);
    chk(rx_data, 8'h5A);
    repeat (4) begin
      i_host.xfer(8'hA7, got, 80);
      i_host.xfer(8'hB4, got, 80);
    end
    cyc(20);
    chk(rx_count < 11'd6, 1);
    chk(sync_err, 0);
    tx_data <= 8'hC3;
    tx_valid <= 1'b1;
    cyc(1);
    tx_valid <= 1'b0;
    tx_en <= 1'b1;
    cyc(1);
    tx_en <= 1'b0;
    cyc(10);
    i_host.xfer(8'hA7, got, 80); // next byte is fetched one frame ahead
    i_host.xfer(8'hA7, got, 80);
    chk(got, 8'hC3);
    prst <= 1'b1;
    cyc(1);
    prst <= 1'b0;
    cyc(6);
    chk({rx_empty, tx_empty}, 2'b11);
  endtask
  initial begin
    {err_total, checks_done} = 0;
    {nrst, mrst_n, clk_en, strap_spi} = 4'b0111;
    {tog, m_per, m_cyc, wk_done, sd_done, rate_load} = 6'h00;
    {tx_valid, rx_pop, tx_en, prst, proto_sel, rate_sel} = 10'h000;
    {tx_data, tx_th, rx_th} = {8'h00, 11'd0, 11'd1};
    cyc(8);
    nrst <= 1'b1;
    cyc(4);
    chk({pwr, proto_out, tx_empty, rx_empty, tx_full}, 6'h06);
    chk({oe_n, tx_irq, tx_count}, {2'b11, 11'd0});
    chk(mark, 1);
    t_toggle();
    t_mrst();
    t_spi();
    give_verdict();
  end
endmodule // rhi_core_tb
